/* File: logic/scsc_pkg.sv */
// shared constants and types of the crypto scramble command block
package scsc_pkg;

    localparam logic [7:0]  CMD_SANITIZE      = 8'hB4;
    localparam logic [15:0] FEAT_CRYPTO       = 16'h0011;
    localparam logic [7:0]  SIG_SECT_CUR      = 8'h70;
    localparam logic [7:0]  SIG_SECT_PREV     = 8'h43;
    localparam logic [7:0]  SIG_CYL_LO_CUR    = 8'h79;
    localparam logic [7:0]  SIG_CYL_HI_CUR    = 8'h72;

    localparam int          FAIL_OPT_BIT      = 4;
    localparam int          CNT_DONE_BIT      = 15;
    localparam int          CNT_RUN_BIT       = 14;
    localparam int          CNT_FROZEN_BIT    = 13;
    localparam int          ERR_ABORT_BIT     = 2;

    localparam logic [15:0] PROGRESS_IDLE     = 16'hFFFF;
    localparam logic [7:0]  REASON_NONE       = 8'h00;
    localparam logic [7:0]  REASON_UNSANITIZED = 8'h01;
    localparam logic [7:0]  REASON_BAD_FEAT   = 8'h02;
    localparam logic [7:0]  REASON_FROZEN     = 8'h03;

    // status byte: ready and seek complete, plus error bit on abort
    localparam logic [7:0]  STAT_OK           = 8'h50;
    localparam logic [7:0]  STAT_ERR          = 8'h51;
    localparam logic [7:0]  STAT_RESET        = 8'h00;
    localparam logic [7:0]  ERR_ABORTED       = 8'h04;
    localparam logic [7:0]  ERR_NONE          = 8'h00;

    typedef enum logic [2:0] {
        SANITIZE_IDLE_STATE      = 3'b000,
        SANITIZE_FROZEN_STATE    = 3'b001,
        SANITIZE_RUNNING_STATE   = 3'b010,
        SANITIZE_FAILED_STATE    = 3'b011,
        SANITIZE_SUCCEEDED_STATE = 3'b100
    } scsc_state_e;

    // command block as written by the host
    typedef struct packed {
        logic [7:0]  command;
        logic [15:0] feature;
        logic [15:0] sector_count;
        logic [7:0]  sect_cur;
        logic [7:0]  sect_prev;
        logic [7:0]  cyl_lo_cur;
        logic [7:0]  cyl_hi_cur;
    } scsc_cmd_s;

    // result block returned to the host
    typedef struct packed {
        logic [7:0]  command_error_flags;
        logic [7:0]  device_condition_flags;
        logic [15:0] sector_count;
        logic [7:0]  sect_num;
        logic [7:0]  cyl_lo;
    } scsc_result_s;

endpackage : scsc_pkg

/* File: logic/scsc_top.sv */
// crypto scramble sanitize command interpreter, device side
`timescale 1ns/100ps
//
// Behaviour
// - advertise only when keys cover all data
// - accepted command starts key replacement
// - user data may read indeterminate afterwards
// - process only in idle, failed, succeeded
// - option one lets status command exit failed
// - option zero: failed aborts option-one commands
// - count bit 15: succeeded one, running zero
// - completion bit kept across power cycles
// - bit 14 running, bit 13 frozen
// - progress split cylinder low, sector number
// - progress FFFFh outside running state
// - progress is numerator over 65536
// - abort after freeze lock since power-on
// - abort failed, last option zero, new one
// - reason code in sector number byte
module scsc_top #(
    parameter int PROG_W = 16
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_clk_en,
    input  wire logic                  i_sanitize_supported,
    input  wire logic                  i_keys_cover_all,
    input  wire logic                  i_cmd_valid,
    input  wire scsc_pkg::scsc_cmd_s   i_cmd,
    input  wire logic                  i_freeze_lock_ok,
    input  wire logic                  i_status_cmd_ok,
    input  wire logic                  i_scramble_done,
    input  wire logic                  i_scramble_fail,
    input  wire logic [PROG_W-1:0]     i_scramble_progress,
    input  wire logic                  i_nv_done_bit,
    output logic                       o_crypto_supported,
    output logic                       o_busy,
    output logic                       o_result_valid,
    output scsc_pkg::scsc_result_s     o_result,
    output logic                       o_scramble_start,
    output logic                       o_nv_done_write,
    output logic                       o_nv_done_bit,
    output logic [2:0]                 o_sanitize_state
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        scsc_pkg::scsc_state_e  state;
        logic                   nv_loaded;
        logic                   nv_done;
        logic                   nv_write;
        logic                   frozen_since_por;
        logic                   last_fail_opt;
        logic [7:0]             reason;
        logic [15:0]            progress;
        logic                   start;
        logic                   result_valid;
        logic                   busy;
        scsc_pkg::scsc_result_s result;
    } scsc_regs_s;

    scsc_regs_s state_q;
    scsc_regs_s state_d;

    function automatic logic sig_ok(input scsc_pkg::scsc_cmd_s c);
        sig_ok = (c.sect_cur == scsc_pkg::SIG_SECT_CUR) &&
                 (c.sect_prev == scsc_pkg::SIG_SECT_PREV) &&
                 (c.cyl_lo_cur == scsc_pkg::SIG_CYL_LO_CUR) &&
                 (c.cyl_hi_cur == scsc_pkg::SIG_CYL_HI_CUR);
    endfunction : sig_ok

    // returned count word and progress bytes built from the state passed in
    function automatic scsc_pkg::scsc_result_s build_result(
        input scsc_regs_s   s,
        input logic         abort,
        input logic [7:0]   why
    );
        scsc_pkg::scsc_result_s r;
        logic [15:0]            prog;
        r = '0;
        prog = (s.state == scsc_pkg::SANITIZE_RUNNING_STATE) ?
               s.progress : scsc_pkg::PROGRESS_IDLE;
        r.sector_count[scsc_pkg::CNT_DONE_BIT]   = s.nv_done;
        r.sector_count[scsc_pkg::CNT_RUN_BIT]    =
            (s.state == scsc_pkg::SANITIZE_RUNNING_STATE);
        r.sector_count[scsc_pkg::CNT_FROZEN_BIT] =
            (s.state == scsc_pkg::SANITIZE_FROZEN_STATE);
        if (abort) begin
            r.command_error_flags    = scsc_pkg::ERR_ABORTED;
            r.device_condition_flags = scsc_pkg::STAT_ERR;
            r.sect_num               = why;
            r.cyl_lo                 = prog[15:8];
        end else begin
            r.command_error_flags    = scsc_pkg::ERR_NONE;
            r.device_condition_flags = scsc_pkg::STAT_OK;
            r.sect_num               = prog[7:0];
            r.cyl_lo                 = prog[15:8];
        end
        build_result = r;
    endfunction : build_result

    ////////////////////////////////////////////////////////////////////////
    logic       cmd_is_ours;
    logic       fail_opt;
    logic       state_allows;
    logic       abort;
    logic [7:0] abort_why;

    assign cmd_is_ours = i_cmd_valid && (i_cmd.command == scsc_pkg::CMD_SANITIZE);
    assign fail_opt    = i_cmd.sector_count[scsc_pkg::FAIL_OPT_BIT];

    always_comb begin
        state_allows = (state_q.state == scsc_pkg::SANITIZE_IDLE_STATE) ||
                       (state_q.state == scsc_pkg::SANITIZE_FAILED_STATE) ||
                       (state_q.state == scsc_pkg::SANITIZE_SUCCEEDED_STATE);
        abort     = 1'b0;
        abort_why = scsc_pkg::REASON_NONE;
        // priority: support, feature, freeze, state, failure option
        if (!i_sanitize_supported || !i_keys_cover_all) begin
            abort = 1'b1;
        end else if (i_cmd.feature != scsc_pkg::FEAT_CRYPTO || !sig_ok(i_cmd)) begin
            abort     = 1'b1;
            abort_why = scsc_pkg::REASON_BAD_FEAT;
        end else if (state_q.frozen_since_por ||
                     state_q.state == scsc_pkg::SANITIZE_FROZEN_STATE) begin
            abort     = 1'b1;
            abort_why = scsc_pkg::REASON_FROZEN;
        end else if (!state_allows) begin
            abort = 1'b1;
        end else if (state_q.state == scsc_pkg::SANITIZE_FAILED_STATE &&
                     !state_q.last_fail_opt && fail_opt) begin
            abort     = 1'b1;
            abort_why = state_q.reason;
        end
    end

    always_comb begin
        state_d              = state_q;
        state_d.start        = 1'b0;
        state_d.result_valid = 1'b0;
        state_d.nv_write     = 1'b0;
        state_d.busy         = 1'b0;
        // retained completion bit is picked up once after reset release
        if (!state_q.nv_loaded) begin
            state_d.nv_loaded = 1'b1;
            state_d.nv_done   = i_nv_done_bit;
        end
        if (state_q.state == scsc_pkg::SANITIZE_RUNNING_STATE) begin
            state_d.progress = i_scramble_progress;
        end
        case (state_q.state)
            scsc_pkg::SANITIZE_RUNNING_STATE: begin
                state_d.busy = 1'b1;
                if (i_scramble_done) begin
                    if (i_scramble_fail) begin
                        state_d.state  = scsc_pkg::SANITIZE_FAILED_STATE;
                        state_d.reason = scsc_pkg::REASON_UNSANITIZED;
                    end else begin
                        state_d.state    = scsc_pkg::SANITIZE_SUCCEEDED_STATE;
                        state_d.nv_done  = 1'b1;
                        state_d.nv_write = 1'b1;
                    end
                end
            end
            scsc_pkg::SANITIZE_FAILED_STATE: begin
                if (i_status_cmd_ok && state_q.last_fail_opt) begin
                    state_d.state  = scsc_pkg::SANITIZE_IDLE_STATE;
                    state_d.reason = scsc_pkg::REASON_NONE;
                end
            end
            scsc_pkg::SANITIZE_SUCCEEDED_STATE: begin
                if (i_status_cmd_ok) begin
                    state_d.state = scsc_pkg::SANITIZE_IDLE_STATE;
                end
            end
            scsc_pkg::SANITIZE_IDLE_STATE: begin
                state_d.state = scsc_pkg::SANITIZE_IDLE_STATE;
            end
            scsc_pkg::SANITIZE_FROZEN_STATE: begin
                state_d.state = scsc_pkg::SANITIZE_FROZEN_STATE;
            end
            default: begin
                state_d.state = scsc_pkg::SANITIZE_IDLE_STATE;
            end
        endcase
        if (i_freeze_lock_ok && state_q.state != scsc_pkg::SANITIZE_RUNNING_STATE) begin
            state_d.state            = scsc_pkg::SANITIZE_FROZEN_STATE;
            state_d.frozen_since_por = 1'b1;
        end
        if (cmd_is_ours) begin
            if (abort) begin
                state_d.result = build_result(state_q, 1'b1, abort_why);
            end else begin
                // key replacement leaves stored data unreadable; contents
                // of the user area are not defined after this point
                state_d.start         = 1'b1;
                state_d.state         = scsc_pkg::SANITIZE_RUNNING_STATE;
                state_d.last_fail_opt = fail_opt;
                state_d.progress      = '0;
                state_d.nv_done       = 1'b0;
                state_d.nv_write      = 1'b1;
                state_d.reason        = scsc_pkg::REASON_NONE;
                // answer shows the state just entered: running, progress zero
                state_d.result        = build_result(state_d, 1'b0, scsc_pkg::REASON_NONE);
            end
            state_d.result_valid = 1'b1;
            state_d.busy         = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= '0;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign o_crypto_supported = i_sanitize_supported && i_keys_cover_all;
    assign o_busy             = state_q.busy;
    assign o_result_valid     = state_q.result_valid;
    assign o_result           = state_q.result;
    assign o_scramble_start   = state_q.start;
    assign o_nv_done_write    = state_q.nv_write;
    assign o_nv_done_bit      = state_q.nv_done;
    assign o_sanitize_state   = state_q.state;

endmodule : scsc_top

/* File: verif/scsc_key_engine_model.sv */
// key engine and retained completion store facing the command block
`timescale 1ns/100ps
module scsc_key_engine_model #(
    parameter int DELAY = 20
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_start,
    input  wire logic        i_fail_next,
    input  wire logic        i_nv_write,
    input  wire logic        i_nv_bit,
    output logic             o_done,
    output logic             o_fail,
    output logic [15:0]      o_progress,
    output logic             o_nv_bit
);
    int cnt = 0;
    // store has no reset: it must survive a power cycle
    initial begin
        o_nv_bit = 1'b0;
        o_done = 1'b0;
        o_progress = 16'h0000;
    end
    assign o_fail = i_fail_next;
    always @(posedge i_core_clk) begin
        o_done <= 1'b0;
        if (i_nv_write) o_nv_bit <= i_nv_bit;
        if (i_start) begin
            cnt <= DELAY;
            o_progress <= 16'h0000;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            o_progress <= o_progress + 16'h0800;
            o_done <= (cnt == 1);
        end
    end
endmodule : scsc_key_engine_model

/* File: verif/scsc_top_asserts.sv */
// assertions on the crypto scramble command block ports
`timescale 1ns/100ps
module scsc_top_asserts (
    input wire logic                 i_core_clk,
    input wire logic                 i_rst_b,
    input wire logic                 i_clk_en,
    input wire logic                 i_sanitize_supported,
    input wire logic                 i_keys_cover_all,
    input wire logic                 i_cmd_valid,
    input wire scsc_pkg::scsc_cmd_s  i_cmd,
    input wire logic                 i_scramble_done,
    input wire logic                 i_scramble_fail,
    input wire logic                 o_crypto_supported,
    input wire logic                 o_busy,
    input wire logic                 o_result_valid,
    input wire scsc_pkg::scsc_result_s o_result,
    input wire logic                 o_scramble_start,
    input wire logic                 o_nv_done_write,
    input wire logic                 o_nv_done_bit,
    input wire logic [2:0]           o_sanitize_state
);
    logic take;
    logic run;
    assign take = i_clk_en && i_cmd_valid && i_cmd.command == 8'hB4;
    assign run = o_sanitize_state == 3'b010;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////
    AST_SUPPORT: assert property (o_crypto_supported == (i_sanitize_supported && i_keys_cover_all))
        else $error("support flag wrong");
    AST_ANSWER: assert property (take |=> o_result_valid)
        else $error("no result one cycle after command");
    AST_START: assert property (o_scramble_start |-> o_result_valid && run && o_result.command_error_flags == 8'h00)
        else $error("start without accepted result");
    AST_COUNT_BITS: assert property (o_scramble_start |-> o_result.sector_count[15:13] == 3'b010)
        else $error("count flags wrong on accept");
    AST_ABORT: assert property (o_result_valid && o_result.command_error_flags[2] |->
        o_result.device_condition_flags == 8'h51 && !o_busy && !o_scramble_start)
        else $error("abort status wrong");
    AST_RUN_REFUSE: assert property (take && run |=> o_result.command_error_flags == 8'h04)
        else $error("command taken while running");
    AST_FROZEN: assert property (take && o_sanitize_state == 3'b001 |=> o_result.command_error_flags == 8'h04)
        else $error("command taken while frozen");
    AST_DONE: assert property (i_clk_en && run && i_scramble_done && !i_scramble_fail |=>
        o_sanitize_state == 3'b100 && o_nv_done_bit && o_nv_done_write)
        else $error("success not recorded");
    AST_FAIL: assert property (i_clk_en && run && i_scramble_done && i_scramble_fail |=> o_sanitize_state == 3'b011)
        else $error("failure not recorded");
    AST_BUSY: assert property ($rose(o_busy) |-> $past(o_scramble_start || o_result_valid) && run)
        else $error("busy without start");
    cover property (o_scramble_start);
    cover property (o_result_valid && o_result.sect_num == 8'h03);
    cover property (run && i_scramble_done && i_scramble_fail);
endmodule : scsc_top_asserts
bind scsc_top scsc_top_asserts u_chk (.i_core_clk, .i_rst_b, .i_clk_en, .i_sanitize_supported,
    .i_keys_cover_all, .i_cmd_valid, .i_cmd, .i_scramble_done, .i_scramble_fail, .o_crypto_supported,
    .o_busy, .o_result_valid, .o_result, .o_scramble_start, .o_nv_done_write, .o_nv_done_bit, .o_sanitize_state);

/* File: verif/test_sanitize_crypto_scramble_cmd.sv */
// self-checking bench of the crypto scramble command block
`timescale 1ns/100ps
module test_sanitize_crypto_scramble_cmd;
    typedef struct packed {logic [7:0] err; logic [7:0] stat; logic [7:0] why; logic full;} scsc_exp_s;
    logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_clk_en = 1'b1, i_sanitize_supported = 1'b1;
    logic i_keys_cover_all = 1'b1, i_cmd_valid = 1'b0, i_freeze_lock_ok = 1'b0, i_status_cmd_ok = 1'b0;
    logic i_scramble_done, i_scramble_fail, i_nv_done_bit, fail_next = 1'b0;
    logic o_crypto_supported, o_busy, o_result_valid, o_scramble_start, o_nv_done_write, o_nv_done_bit;
    scsc_pkg::scsc_cmd_s    i_cmd = {8'hB4, 16'h0011, 16'h0000, 8'h70, 8'h43, 8'h79, 8'h72};
    scsc_pkg::scsc_result_s o_result;
    logic [15:0]            i_scramble_progress;
    logic [15:0]            f;
    logic [2:0]             o_sanitize_state;
    scsc_exp_s              e;
    scsc_exp_s              exp_q[$];
    int                     failures = 0;
    int                     check_count = 0;
    always #50 i_core_clk = ~i_core_clk;
    scsc_top dut_u (.i_core_clk, .i_rst_b, .i_clk_en, .i_sanitize_supported, .i_keys_cover_all, .i_cmd_valid,
        .i_cmd, .i_freeze_lock_ok, .i_status_cmd_ok, .i_scramble_done, .i_scramble_fail, .i_scramble_progress,
        .i_nv_done_bit, .o_crypto_supported, .o_busy, .o_result_valid, .o_result, .o_scramble_start,
        .o_nv_done_write, .o_nv_done_bit, .o_sanitize_state);
    scsc_key_engine_model eng_u (.i_core_clk, .i_start(o_scramble_start), .i_fail_next(fail_next),
        .i_nv_write(o_nv_done_write), .i_nv_bit(o_nv_done_bit), .o_done(i_scramble_done),
        .o_fail(i_scramble_fail), .o_progress(i_scramble_progress), .o_nv_bit(i_nv_done_bit));
    ////////////////////////////////////////////////////////////////
    task automatic err(input string m);
        $display("[ERR] %0t %s", $time, m);
        failures++;
    endtask : err
    task automatic check(input logic c, input string m);
        check_count++;
        if (c !== 1'b1) err(m);
    endtask : check
    task automatic results();
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    // host side of the command block; signature xor sx corrupts it
    task automatic send(input logic [15:0] feat, input logic opt, input logic [7:0] sx, input logic ok,
                        input logic [7:0] why);
        @(posedge i_core_clk);
        i_cmd_valid <= 1'b1;
        i_cmd.feature <= feat;
        i_cmd.sector_count <= {11'h000, opt, 4'h0};
        i_cmd.sect_cur <= 8'h70 ^ sx;
        exp_q.push_back({ok ? 8'h00 : 8'h04, ok ? 8'h50 : 8'h51, why, ok});
        @(posedge i_core_clk);
        i_cmd_valid <= 1'b0;
    endtask : send
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        @(negedge i_core_clk);
        while (o_sanitize_state !== s && n < 60) begin
            @(negedge i_core_clk);
            n++;
        end
        check(o_sanitize_state === s, "state");
    endtask : wait_state
    ////////////////////////////////////////////////////////////////
    always @(negedge i_core_clk) begin
        if (o_result_valid === 1'b1) begin
            check_count++;
            if (exp_q.size() == 0) err("unexpected result");
            else begin
                e = exp_q.pop_front();
                if (o_result.command_error_flags !== e.err || o_result.device_condition_flags !== e.stat
                    || o_result.sect_num !== e.why
                    || (e.full && {o_result.sector_count, o_result.cyl_lo} !== 24'h4000_00)) err("result");
            end
        end
    end
    initial begin
        repeat (3000) @(posedge i_core_clk);
        err("timeout");
        results();
    end
    initial begin
        void'($urandom(64660));
        repeat (8) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_keys_cover_all <= 1'b0;
        i_sanitize_supported <= 1'b0;
        @(negedge i_core_clk) check(o_crypto_supported === 1'b0, "support");
        send(16'h0011, 1'b0, 8'h00, 1'b0, 8'h00);
        i_sanitize_supported <= 1'b1;
        i_keys_cover_all <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            f = 16'($urandom);
            if (f == 16'h0011) f = 16'h0012;
            send(k[0] ? 16'h0011 : f, 1'b0, k[0] ? 8'($urandom_range(1, 255)) : 8'h00, 1'b0, 8'h02);
        end
        fail_next <= 1'b1;
        send(16'h0011, 1'b0, 8'h00, 1'b1, 8'h00);
        send(16'h0011, 1'b0, 8'h00, 1'b0, 8'h00);
        wait_state(3'b011);
        send(16'h0011, 1'b1, 8'h00, 1'b0, 8'h01);
        @(posedge i_core_clk) i_status_cmd_ok <= 1'b1;
        @(posedge i_core_clk) i_status_cmd_ok <= 1'b0;
        wait_state(3'b011);
        fail_next <= 1'b0;
        send(16'h0011, 1'b0, 8'h00, 1'b1, 8'h00);
        wait_state(3'b100);
        check(o_nv_done_bit === 1'b1, "done bit");
        @(posedge i_core_clk) i_rst_b <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk) check(o_nv_done_bit === 1'b1 && o_sanitize_state === 3'b000, "retained");
        fail_next <= 1'b1;
        send(16'h0011, 1'b1, 8'h00, 1'b1, 8'h00);
        wait_state(3'b011);
        @(posedge i_core_clk) i_status_cmd_ok <= 1'b1;
        @(posedge i_core_clk) i_status_cmd_ok <= 1'b0;
        wait_state(3'b000);
        @(posedge i_core_clk) i_freeze_lock_ok <= 1'b1;
        @(posedge i_core_clk) i_freeze_lock_ok <= 1'b0;
        send(16'h0011, 1'b0, 8'h00, 1'b0, 8'h03);
        wait_state(3'b001);
        repeat (3) @(posedge i_core_clk);
        check(exp_q.size() == 0, "missing result");
        results();
    end
endmodule : test_sanitize_crypto_scramble_cmd
